/* File: hdl/ppg_map.vh */
/*
  Register map, reset values and timing constants of the positioning
  pulse generator. Included by the pulse generator top; holds definitions only.
*/
`ifndef PPG_MAP_VH
`define PPG_MAP_VH

`define PPG_CTRL_OFS 12'h000
`define PPG_UPPER_OFS 12'h004
`define PPG_LOWER_OFS 12'h008
`define PPG_SPDLIM_OFS 12'h00C
`define PPG_BIAS_OFS 12'h010
`define PPG_SPEED_OFS 12'h014
`define PPG_ACCEL_OFS 12'h018
`define PPG_MOVE_OFS 12'h01C
`define PPG_CMD_OFS 12'h020
`define PPG_STATUS_OFS 12'h024
`define PPG_POS_OFS 12'h028
`define PPG_INPUTS_OFS 12'h02C

`define PPG_CTRL_MODE_LSB 0
`define PPG_CTRL_DIRSET_BIT 2
`define PPG_CTRL_SCURVE_BIT 3
`define PPG_CTRL_FLS_EN_BIT 4
`define PPG_CTRL_RLS_EN_BIT 5

`define PPG_CMD_START_BIT 0
`define PPG_CMD_REV_BIT 1
`define PPG_CMD_STOP_BIT 2
`define PPG_CMD_CLRERR_BIT 3

`define PPG_MODE_FWDREV 2'h0
`define PPG_MODE_PLSDIR 2'h1
`define PPG_MODE_QUAD1 2'h2
`define PPG_MODE_QUAD4 2'h3

`define PPG_CTRL_RST 32'h00000000
`define PPG_UPPER_RST 32'h7FFFFFFF
`define PPG_LOWER_RST 32'h80000000
`define PPG_SPDLIM_RST 32'h00002710
`define PPG_SPDLIM_MAX 32'h00030D40
`define PPG_BIAS_RST 32'h00000000
`define PPG_SPEED_RST 32'h00000000
`define PPG_ACCEL_RST 32'h00000000

`define PPG_CLK_HZ 250000000
`define PPG_DIR_SETUP_US 100
`define PPG_PULSE_W_NS 2500
`define PPG_TICK_US 1000

`endif

/* File: hdl/ppg_top.v */
/*
  Positioning pulse generator for one axis: AHB-Lite register slave,
  speed ramp, command pulse output in four formats, current position
  and stroke limit checks.
  Assumes a single hclk at 250 MHz, zero-wait AHB-Lite single word
  transfers, and limit and general inputs arriving asynchronously.
*/
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ppg_map.vh"

module ppg_top #(
  parameter DIR_SETUP_CYC = (`PPG_DIR_SETUP_US * (`PPG_CLK_HZ / 1000000)),
  parameter TICK_CYC = (`PPG_TICK_US * (`PPG_CLK_HZ / 1000000)),
  parameter FLS_BIT = 0,
  parameter RLS_BIT = 1
) (
  input wire hclk, // Bus and logic clock
  input wire hresetn, // Asynchronous reset, active low
  input wire hsel, // Slave select
  input wire [11:0] haddr, // Byte address
  input wire [1:0] htrans, // Transfer type
  input wire hwrite, // Write when high
  input wire [2:0] hsize, // Transfer size, word only
  input wire [31:0] hwdata, // Write data
  input wire hready, // Bus ready in
  output wire hreadyout, // Always ready
  output wire hresp, // Always OKAY
  output reg [31:0] hrdata, // Read data
  input wire [5:0] fast_inputs, // Fast general inputs
  input wire [9:0] normal_inputs, // General inputs, limit switches among them
  output reg forward_pulse_out, // Forward line, pulse line or phase A
  output reg reverse_pulse_out, // Reverse line, direction level or phase B
  output wire busy, // Motion in progress
  output wire error // Error latched
);

  localparam PULSE_W_CYC = (`PPG_PULSE_W_NS * (`PPG_CLK_HZ / 1000000)) / 1000;
  localparam [31:0] CLK_HZ = `PPG_CLK_HZ;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SETUP = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;

  function [31:0] clamp_to;
    input [31:0] val;
    input [31:0] lim;
    begin
      clamp_to = (val > lim) ? lim : val;
    end
  endfunction

  reg [31:0] ctrl_reg, upper_reg, lower_reg, spdlim_reg, bias_reg;
  reg [31:0] speed_reg, accel_reg, move_reg, pos_reg;
  reg [1:0] state_reg;
  reg dir_rev_reg, err_reg, lim_stop_reg, soft_stop_reg;
  reg [31:0] remain_reg, ramp_pulses_reg, rate_reg, acc_reg;
  reg [31:0] wait_reg, tick_reg;
  reg [15:0] pw_reg;
  reg [1:0] quad_reg, quarter_reg;
  reg [5:0] fast_s1_reg, fast_s2_reg;
  reg [9:0] norm_s1_reg, norm_s2_reg;
  reg wr_pend_reg;
  reg [11:0] wr_addr_reg;

  wire [1:0] mode = ctrl_reg[`PPG_CTRL_MODE_LSB +: 2];
  wire dir_set_rev = ctrl_reg[`PPG_CTRL_DIRSET_BIT];
  wire scurve = ctrl_reg[`PPG_CTRL_SCURVE_BIT];

  // AHB-Lite slave: zero wait states, read data registered in the address phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  wire addr_ok = hsel && htrans[1] && hready;
  wire rd_go = addr_ok && !hwrite;
  wire wr_go = wr_pend_reg;
  wire cmd_wr = wr_go && (wr_addr_reg == `PPG_CMD_OFS);

  // Inputs come straight from the optocouplers: high means voltage applied
  // and reads as on
  wire fls_on = norm_s2_reg[FLS_BIT];
  wire rls_on = norm_s2_reg[RLS_BIT];

  // Clamped speeds
  wire [31:0] spd_lim = spdlim_reg;
  wire [31:0] tgt_rate = clamp_to(speed_reg, spd_lim);
  wire [31:0] bias_c = clamp_to(bias_reg, spd_lim);
  wire [31:0] floor_rate = (bias_c == 32'h00000000) ? 32'h00000001 : bias_c;
  wire [31:0] start_rate = (accel_reg == 32'h00000000) ? tgt_rate :
                           ((tgt_rate > floor_rate) ? floor_rate : tgt_rate);

  // Edge rate: quadrature x1 needs four edges for one command pulse
  wire [31:0] edge_rate = (mode == `PPG_MODE_QUAD1) ? {rate_reg[29:0], 2'b00} : rate_reg;
  wire [31:0] acc_sum = acc_reg + edge_rate;
  wire edge_ev = (state_reg == ST_RUN) && (acc_sum >= CLK_HZ);

  // One command pulse is completed by this edge event
  wire cmd_pulse = edge_ev && ((mode != `PPG_MODE_QUAD1) || (quarter_reg == 2'h3));

  // Forward pulses count up unless the direction setting says otherwise
  wire pos_up = dir_rev_reg ^ ~dir_set_rev;
  wire [31:0] pos_next = pos_up ? pos_reg + 32'h00000001 : pos_reg - 32'h00000001;

  // Stroke check on the position the next pulse would reach
  wire soft_en = (upper_reg != lower_reg);
  wire soft_hit = soft_en && (pos_up ? ($signed(pos_next) > $signed(upper_reg)) :
                                       ($signed(pos_next) < $signed(lower_reg)));

  // Limit switch off while enabled halts motion
  wire hw_hit = (ctrl_reg[`PPG_CTRL_FLS_EN_BIT] && !fls_on) ||
                (ctrl_reg[`PPG_CTRL_RLS_EN_BIT] && !rls_on);

  wire moving = (state_reg != ST_IDLE);
  assign busy = moving;
  assign error = err_reg;

  // Ramp increment; the S-curve softens both ends of the ramp
  wire [31:0] inc_full = accel_reg;
  wire near_end = ((rate_reg - floor_rate) < {inc_full[29:0], 2'b00}) ||
                  ((tgt_rate - rate_reg) < {inc_full[29:0], 2'b00});
  wire [31:0] ramp_inc = (scurve && near_end) ? {1'b0, inc_full[31:1]} : inc_full;
  wire decel = (remain_reg <= ramp_pulses_reg);
  wire tick = (tick_reg == 32'h00000000);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fast_s1_reg <= 6'h00;
      fast_s2_reg <= 6'h00;
      norm_s1_reg <= 10'h000;
      norm_s2_reg <= 10'h000;
    end else begin
      fast_s1_reg <= fast_inputs;
      fast_s2_reg <= fast_s1_reg;
      norm_s1_reg <= normal_inputs;
      norm_s2_reg <= norm_s1_reg;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      if (addr_ok)
        wr_addr_reg <= haddr;
      if (rd_go) begin
        case (haddr)
          `PPG_CTRL_OFS: hrdata <= ctrl_reg;
          `PPG_UPPER_OFS: hrdata <= upper_reg;
          `PPG_LOWER_OFS: hrdata <= lower_reg;
          `PPG_SPDLIM_OFS: hrdata <= spdlim_reg;
          `PPG_BIAS_OFS: hrdata <= bias_reg;
          `PPG_SPEED_OFS: hrdata <= speed_reg;
          `PPG_ACCEL_OFS: hrdata <= accel_reg;
          `PPG_MOVE_OFS: hrdata <= remain_reg;
          `PPG_STATUS_OFS: hrdata <= {26'h0000000, state_reg, dir_rev_reg,
                                      soft_stop_reg, lim_stop_reg, err_reg};
          `PPG_POS_OFS: hrdata <= pos_reg;
          `PPG_INPUTS_OFS: hrdata <= {16'h0000, fast_s2_reg, norm_s2_reg};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Parameter registers; one set per axis, used by every kind of motion
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `PPG_CTRL_RST;
      upper_reg <= `PPG_UPPER_RST;
      lower_reg <= `PPG_LOWER_RST;
      spdlim_reg <= `PPG_SPDLIM_RST;
      bias_reg <= `PPG_BIAS_RST;
      speed_reg <= `PPG_SPEED_RST;
      accel_reg <= `PPG_ACCEL_RST;
      move_reg <= 32'h00000000;
    end else if (wr_go) begin
      case (wr_addr_reg)
        `PPG_CTRL_OFS: ctrl_reg <= {26'h0000000, hwdata[5:0]};
        `PPG_UPPER_OFS: upper_reg <= hwdata;
        `PPG_LOWER_OFS: lower_reg <= hwdata;
        // Out-of-range limit values are pulled into 1..200000
        `PPG_SPDLIM_OFS: spdlim_reg <= (hwdata == 32'h00000000) ? 32'h00000001 :
                                      clamp_to(hwdata, `PPG_SPDLIM_MAX);
        `PPG_BIAS_OFS: bias_reg <= clamp_to(hwdata, `PPG_SPDLIM_MAX);
        `PPG_SPEED_OFS: speed_reg <= hwdata;
        `PPG_ACCEL_OFS: accel_reg <= hwdata;
        `PPG_MOVE_OFS: move_reg <= hwdata;
        default: ;
      endcase
    end
  end

  // Motion sequencer, ramp, position and stop handling
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
      dir_rev_reg <= 1'b0;
      err_reg <= 1'b0;
      lim_stop_reg <= 1'b0;
      soft_stop_reg <= 1'b0;
      remain_reg <= 32'h00000000;
      ramp_pulses_reg <= 32'h00000000;
      rate_reg <= 32'h00000000;
      acc_reg <= 32'h00000000;
      wait_reg <= 32'h00000000;
      tick_reg <= 32'h00000000;
      pos_reg <= 32'h00000000;
    end else begin
      tick_reg <= tick ? TICK_CYC - 1 : tick_reg - 32'h00000001;
      if (cmd_wr && hwdata[`PPG_CMD_CLRERR_BIT] && !moving) begin
        err_reg <= 1'b0;
        lim_stop_reg <= 1'b0;
        soft_stop_reg <= 1'b0;
      end
      // Position preset only while stopped
      if (wr_go && (wr_addr_reg == `PPG_POS_OFS) && !moving)
        pos_reg <= hwdata;
      case (state_reg)
        ST_IDLE: begin
          acc_reg <= 32'h00000000;
          if (cmd_wr && hwdata[`PPG_CMD_START_BIT] && !err_reg &&
              move_reg != 32'h00000000) begin
            dir_rev_reg <= hwdata[`PPG_CMD_REV_BIT];
            remain_reg <= move_reg;
            ramp_pulses_reg <= 32'h00000000;
            rate_reg <= start_rate;
            wait_reg <= DIR_SETUP_CYC;
            // Direction level needs its settling time before a reverse pulse
            state_reg <= (hwdata[`PPG_CMD_REV_BIT] && mode == `PPG_MODE_PLSDIR) ?
                         ST_SETUP : ST_RUN;
          end
        end
        ST_SETUP: begin
          wait_reg <= wait_reg - 32'h00000001;
          if (wait_reg == 32'h00000001)
            state_reg <= ST_RUN;
        end
        ST_RUN: begin
          if (edge_ev)
            acc_reg <= acc_sum - CLK_HZ;
          else
            acc_reg <= acc_sum;
          if (tick) begin
            if (decel)
              rate_reg <= (rate_reg > floor_rate + ramp_inc) ? rate_reg - ramp_inc :
                          floor_rate;
            else if (rate_reg < tgt_rate)
              rate_reg <= clamp_to(rate_reg + ramp_inc, tgt_rate);
            else if (rate_reg > tgt_rate)
              rate_reg <= (rate_reg > tgt_rate + ramp_inc) ? rate_reg - ramp_inc :
                          tgt_rate;
          end
          if (cmd_pulse) begin
            pos_reg <= pos_next;
            remain_reg <= remain_reg - 32'h00000001;
            if (!decel && rate_reg < tgt_rate)
              ramp_pulses_reg <= ramp_pulses_reg + 32'h00000001;
            if (remain_reg == 32'h00000001)
              state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      // Stops override the sequence; the check runs ahead of each command pulse
      if (moving) begin
        if (hw_hit) begin
          state_reg <= ST_IDLE;
          lim_stop_reg <= 1'b1;
          err_reg <= 1'b1;
        // Quadrature edges can come faster than the pulse width, so there only
        // the quarter count gates the check; never stop on an edge being sent
        end else if (state_reg == ST_RUN && soft_hit && quarter_reg == 2'h0 && !edge_ev &&
                     (pw_reg == 16'h0000 || mode[1])) begin
          state_reg <= ST_IDLE;
          soft_stop_reg <= 1'b1;
          err_reg <= 1'b1;
        end else if (cmd_wr && hwdata[`PPG_CMD_STOP_BIT]) begin
          state_reg <= ST_IDLE;
        end
      end
    end
  end

  // Output formatter
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      forward_pulse_out <= 1'b0;
      reverse_pulse_out <= 1'b0;
      pw_reg <= 16'h0000;
      quad_reg <= 2'h0;
      quarter_reg <= 2'h0;
    end else if (err_reg) begin
      // Error output mode is fixed to clear
      forward_pulse_out <= 1'b0;
      reverse_pulse_out <= 1'b0;
      pw_reg <= 16'h0000;
      quad_reg <= 2'h0;
      quarter_reg <= 2'h0;
    end else begin
      if (edge_ev)
        pw_reg <= PULSE_W_CYC[15:0];
      else if (pw_reg != 16'h0000)
        pw_reg <= pw_reg - 16'h0001;
      if (edge_ev) begin
        quarter_reg <= (mode == `PPG_MODE_QUAD1) ? quarter_reg + 2'h1 : 2'h0;
        quad_reg <= dir_rev_reg ? quad_reg - 2'h1 : quad_reg + 2'h1;
      end
      case (mode)
        `PPG_MODE_FWDREV: begin
          // Only the line of the running direction ever pulses
          forward_pulse_out <= (edge_ev || pw_reg > 16'h0001) && !dir_rev_reg;
          reverse_pulse_out <= (edge_ev || pw_reg > 16'h0001) && dir_rev_reg;
        end
        `PPG_MODE_PLSDIR: begin
          forward_pulse_out <= edge_ev || pw_reg > 16'h0001;
          // Direction stays at the last run's level after a stop that latches no error
          reverse_pulse_out <= !dir_rev_reg;
        end
        default: begin
          // State order A,B = 00,10,11,01 gives B lagging A going forward
          forward_pulse_out <= quad_reg[1] ^ quad_reg[0];
          reverse_pulse_out <= quad_reg[1];
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: bench/ppg_props_properties.sv */
/* Concurrent checks on the pulse generator top, bound to ppg_top.
   Assumes zero-wait single-word bus writes, mirrored here to learn the mode. */
`timescale 1ns/1ps
`default_nettype none
`include "ppg_map.vh"
module ppg_props #(
  parameter DIR_SETUP_CYC = 25000,
  parameter FLS_BIT = 0,
  parameter RLS_BIT = 1
) (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, active low
  input wire logic hsel, // Select
  input wire logic [11:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Ready in
  input wire logic hreadyout, // Ready out
  input wire logic hresp, // Response
  input wire logic [31:0] hrdata, // Read data
  input wire logic [9:0] normal_inputs, // Limit switches among them
  input wire logic forward_pulse_out, // Line A
  input wire logic reverse_pulse_out, // Line B
  input wire logic busy, // Moving
  input wire logic error // Error
);
  logic wr_ctl, wr_cmd, rd_un, rev_q;
  logic [5:0] ctl_q;
  logic [15:0] dcnt;
  wire take = hsel && htrans[1] && hready;
  wire [1:0] mode = ctl_q[1:0];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctl <= 1'b0;
      wr_cmd <= 1'b0;
      rd_un <= 1'b0;
      rev_q <= 1'b0;
      ctl_q <= 6'h00;
      dcnt <= 16'h0000;
    end else begin
      wr_ctl <= take && hwrite && haddr == `PPG_CTRL_OFS;
      wr_cmd <= take && hwrite && haddr == `PPG_CMD_OFS;
      rd_un <= take && !hwrite && haddr >= 12'h030;
      if (wr_ctl)
        ctl_q <= hwdata[5:0];
      if (wr_cmd && hwdata[0])
        rev_q <= hwdata[1];
      // Saturate so a long-low direction never wraps into a false short wait
      if (reverse_pulse_out)
        dcnt <= 16'h0000;
      else if (dcnt != 16'hFFFF)
        dcnt <= dcnt + 16'h0001;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_bus_ok;
    hreadyout && !hresp;
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or not okay");
  property p_unmapped;
    rd_un |-> hrdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_sep_excl;
    mode == `PPG_MODE_FWDREV |-> !(forward_pulse_out && reverse_pulse_out);
  endproperty
  a_sep_excl: assert property (p_sep_excl) else $error("both lines high");
  property p_width;
    mode <= 2'h1 && $rose(forward_pulse_out) |=> (forward_pulse_out || error) [*8];
  endproperty
  a_width: assert property (p_width) else $error("pulse too short");
  property p_dir_level;
    mode == `PPG_MODE_PLSDIR && $rose(forward_pulse_out) |-> reverse_pulse_out == !rev_q;
  endproperty
  a_dir_level: assert property (p_dir_level) else $error("direction level wrong");
  property p_dir_wait;
    mode == `PPG_MODE_PLSDIR && $rose(forward_pulse_out) && !reverse_pulse_out
      |-> dcnt >= DIR_SETUP_CYC - 1;
  endproperty
  a_dir_wait: assert property (p_dir_wait) else $error("reverse pulse too early");
  property p_quad_dir;
    mode >= 2'h2 && $rose(forward_pulse_out) && !error |-> reverse_pulse_out == rev_q;
  endproperty
  a_quad_dir: assert property (p_quad_dir) else $error("phase order wrong");
  property p_quad_gray;
    mode >= 2'h2 && !error && !$past(error)
      |-> !($changed(forward_pulse_out) && $changed(reverse_pulse_out));
  endproperty
  a_quad_gray: assert property (p_quad_gray) else $error("both phases moved");
  property p_err_quiet;
    error && $past(error) |-> !forward_pulse_out && !reverse_pulse_out;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("output during error");
  property p_limit;
    busy && (($fell(normal_inputs[FLS_BIT]) && ctl_q[4]) ||
      ($fell(normal_inputs[RLS_BIT]) && ctl_q[5])) |-> ##[1:5] !busy;
  endproperty
  a_limit: assert property (p_limit) else $error("no stop on limit");
endmodule
bind ppg_top ppg_props #(.DIR_SETUP_CYC(DIR_SETUP_CYC), .FLS_BIT(FLS_BIT), .RLS_BIT(RLS_BIT))
  i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .normal_inputs(normal_inputs), .forward_pulse_out(forward_pulse_out),
  .reverse_pulse_out(reverse_pulse_out), .busy(busy), .error(error));
`default_nettype wire

/* File: bench/ppg_drive_model.sv */
/* Drive unit model: decodes the two command lines into net steps.
   Assumes the bench tells it which output format is set. */
`timescale 1ns/1ps
`default_nettype none
module ppg_drive_model (
  input wire logic hclk, // Sampling clock
  input wire logic [1:0] mode, // Output format
  input wire logic line_a, // Forward, pulse or phase A
  input wire logic line_b, // Reverse, direction or phase B
  output logic signed [31:0] steps // Net steps or edges seen
);
  logic a_q = 1'b0;
  logic b_q = 1'b0;
  initial steps = 0;
  always @(posedge hclk) begin
    a_q <= line_a;
    b_q <= line_b;
    if (mode == 2'h0) begin
      if (line_a && !a_q)
        steps <= steps + 1;
      if (line_b && !b_q)
        steps <= steps - 1;
    end else if (mode == 2'h1) begin
      if (line_a && !a_q)
        steps <= line_b ? steps + 1 : steps - 1;
    end else if (line_a != a_q)
      steps <= (line_a != line_b) ? steps + 1 : steps - 1;
    else if (line_b != b_q)
      steps <= (line_a == line_b) ? steps + 1 : steps - 1;
  end
endmodule
`default_nettype wire

/* File: bench/positioning_pulse_generator_tb_top.sv */
/* Self-checking bench for the pulse generator top with a drive unit model.
   Assumes the zero-wait register slave and shortened direction wait. */
`timescale 1ns/1ps
`default_nettype none
`include "ppg_map.vh"
module positioning_pulse_generator_tb_top;
  logic hclk, hresetn, hsel, hwrite;
  logic [11:0] haddr;
  logic [1:0] htrans, mode;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [5:0] fast_inputs;
  logic [9:0] normal_inputs;
  wire hreadyout, hresp, fwd_out, rev_out, busy, error;
  wire [31:0] hrdata;
  wire signed [31:0] m_steps;
  int err_count, compares;
  ppg_top #(.DIR_SETUP_CYC(20), .TICK_CYC(50)) i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .fast_inputs(fast_inputs), .normal_inputs(normal_inputs),
    .forward_pulse_out(fwd_out), .reverse_pulse_out(rev_out), .busy(busy), .error(error));
  ppg_drive_model i_drv (.hclk(hclk), .mode(mode), .line_a(fwd_out), .line_b(rev_out),
    .steps(m_steps));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task results;
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h00000000, x);
    chk(x, exp);
  endtask
  task go(input logic [5:0] ctl, input logic [31:0] n, input logic r, output int c);
    mode <= ctl[1:0];
    wr(`PPG_CTRL_OFS, {26'h0000000, ctl});
    wr(`PPG_MOVE_OFS, n);
    wr(`PPG_CMD_OFS, {30'h00000000, r, 1'b1});
    c = 0;
    do begin
      @(negedge hclk);
      c++;
    end while (busy === 1'b1 && c < 60000);
    chk({31'h00000000, busy}, 32'h00000000);
    // Let the last pulse finish before the format may change
    repeat (800) @(posedge hclk);
  endtask
  task mv(input logic [5:0] ctl, input int n, input logic r);
    logic [31:0] p0, p1;
    int s0, c, k;
    k = (ctl[1:0] == `PPG_MODE_QUAD1) ? 4 : 1;
    bus(1'b0, `PPG_POS_OFS, 32'h00000000, p0);
    s0 = m_steps;
    go(ctl, n, r, c);
    bus(1'b0, `PPG_POS_OFS, 32'h00000000, p1);
    chk(p1 - p0, (r ^ ctl[2]) ? -n : n);
    chk(m_steps - s0, (r ? -n : n) * k);
  endtask
  task t_reset;
    rdc(`PPG_CTRL_OFS, `PPG_CTRL_RST);
    rdc(`PPG_UPPER_OFS, 32'h7FFFFFFF);
    rdc(`PPG_LOWER_OFS, 32'h80000000);
    rdc(`PPG_SPDLIM_OFS, 32'h00002710);
    rdc(`PPG_BIAS_OFS, 32'h00000000);
    rdc(12'h040, 32'h00000000);
  endtask
  task t_clamp;
    int c;
    wr(`PPG_SPDLIM_OFS, 32'h00000000);
    rdc(`PPG_SPDLIM_OFS, 32'h00000001);
    wr(`PPG_SPDLIM_OFS, 32'h000493E0);
    rdc(`PPG_SPDLIM_OFS, 32'h00030D40);
    wr(`PPG_BIAS_OFS, 32'h000493E0);
    rdc(`PPG_BIAS_OFS, 32'h00030D40);
    wr(`PPG_BIAS_OFS, 32'h00000000);
    wr(`PPG_SPDLIM_OFS, 32'h000186A0);
    wr(`PPG_SPEED_OFS, 32'h00030D40);
    go(6'h00, 32'h00000002, 1'b0, c);
    chk(32'(c >= 4900), 32'h00000001);
    wr(`PPG_SPDLIM_OFS, 32'h00030D40);
  endtask
  task t_modes;
    for (int m = 0; m < 4; m++) begin
      for (int r = 0; r < 2; r++) begin
        mv(6'(m), 3, r[0]);
      end
    end
    mv(6'h04, 3, 1'b0);
    mv(6'h08, 2, 1'b1);
  endtask
  task t_limit;
    int c;
    logic [31:0] st;
    mode <= 2'h0;
    wr(`PPG_CTRL_OFS, 32'h00000010);
    wr(`PPG_MOVE_OFS, 32'h00000064);
    wr(`PPG_CMD_OFS, 32'h00000001);
    repeat (3000) @(posedge hclk);
    normal_inputs <= 10'h002;
    c = 0;
    do begin
      @(negedge hclk);
      c++;
    end while (busy === 1'b1 && c < 20);
    chk(32'(c < 8), 32'h00000001);
    chk(error, 1'b1);
    bus(1'b0, `PPG_STATUS_OFS, 32'h00000000, st);
    chk(st[1], 1'b1);
    normal_inputs <= 10'h003;
    repeat (800) @(posedge hclk);
    wr(`PPG_CMD_OFS, 32'h00000008);
    @(negedge hclk);
    chk(error, 1'b0);
  endtask
  task t_stroke;
    int c;
    logic [31:0] st;
    wr(`PPG_POS_OFS, 32'h00000000);
    wr(`PPG_UPPER_OFS, 32'h00000002);
    wr(`PPG_LOWER_OFS, 32'hFFFFFFFB);
    go(6'h00, 32'h00000005, 1'b0, c);
    rdc(`PPG_POS_OFS, 32'h00000002);
    bus(1'b0, `PPG_STATUS_OFS, 32'h00000000, st);
    chk(st[2], 1'b1);
    wr(`PPG_CMD_OFS, 32'h00000008);
    wr(`PPG_UPPER_OFS, 32'h00000000);
    wr(`PPG_LOWER_OFS, 32'h00000000);
    mv(6'h00, 5, 1'b0);
    chk(error, 1'b0);
  endtask
  task t_bias;
    int c;
    // Tiny ramp: without the bias floor two pulses would take far too long
    wr(`PPG_BIAS_OFS, 32'h000186A0);
    wr(`PPG_ACCEL_OFS, 32'h00000001);
    go(6'h00, 32'h00000002, 1'b0, c);
    chk(32'(c >= 4900 && c <= 5100), 32'h00000001);
    wr(`PPG_ACCEL_OFS, 32'h00000000);
    wr(`PPG_BIAS_OFS, 32'h00000000);
  endtask
  task t_inputs;
    fast_inputs <= 6'h2A;
    normal_inputs <= 10'h2C3;
    repeat (4) @(posedge hclk);
    rdc(`PPG_INPUTS_OFS, {16'h0000, 6'h2A, 10'h2C3});
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    fast_inputs = 6'h00;
    normal_inputs = 10'h003;
    mode = 2'h0;
    err_count = 0;
    compares = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_clamp;
    t_bias;
    t_modes;
    t_limit;
    t_stroke;
    t_inputs;
    results;
  end
  initial begin
    repeat (95000) @(posedge hclk);
    err_count++;
    results;
  end
endmodule
`default_nettype wire
